// file: rtl/age_arbiter.sv
`timescale 1ns/1ps
`include "fpq_consts.svh"
module age_arbiter
    import fpq_pkg::*;
#(
    parameter int N = `FPQ_DEPTH
) (
    // Requesters and their program-order tags
    input wire logic [N-1:0] req,
    input tag_t tag [N],
    // One-hot winner, all zero when nobody asks
    output logic [N-1:0] grant
);

    // Tags wrap, so age is judged by the signed distance between them
    function automatic logic older(tag_t a, tag_t b);
        tag_t d;
        d = b - a;
        return ~d[`TAG_W-1];
    endfunction

    always_comb begin
        int best;
        best = -1;
        grant = '0;
        for (int i = 0; i < N; i++) begin
            if (req[i] && (best < 0 || older(tag[i], tag[best]))) begin
                best = i;
            end
        end
        if (best >= 0) begin
            grant[best] = 1'b1;
        end
    end

endmodule

// file: rtl/fp_int_link_if.sv
`timescale 1ns/1ps
interface fp_int_link_if;
    import fpq_pkg::*;
    logic [`STORE_PORTS-1:0] go;
    iq_idx_t go_idx [`STORE_PORTS];
    word_t go_data [`STORE_PORTS];
    modport fp_end (output go, output go_idx, output go_data);
    modport int_end (input go, input go_idx, input go_data);
endinterface

// file: rtl/fp_issue_queue.sv
// Functional notes
// - Fifteen entries; operate, branch, store, transfer
// - Each entry: add, multiply, store requests
// - Add, multiply one grant; store two
// - Oldest requester wins every arbiter
// - Even entries store port 0, odd port 1
// - Stores and transfers enter both queues together
// - Store request waits for operand readiness
// - Store grant signals twin integer entry
// - Integer issue of twin completes operation
// - Multiply pipelined, result four cycles later
// - Add pipelined, result four cycles later
// - Divide/sqrt via add arbiter, one at once
// - Register file holds 72 physical entries
// - Six read ports: four operand, two store
// - Four write ports: two results, two loads
// - Transfers use integer load write ports
// - Issued entry idles one cycle, then deleted
// - Eight-bit program-order tag per instruction
`timescale 1ns/1ps
`include "fpq_consts.svh"
module fp_issue_queue
    import fpq_pkg::*;
#(
    parameter int DEPTH = `FPQ_DEPTH,
    parameter int NPREG = `PREG_NUM,
    parameter int ADD_LAT = `ADD_LAT,
    parameter int MUL_LAT = `MUL_LAT,
    parameter int DIV_CYC = `DIVSQRT_CYCLES
) (
    // Clock, reset, enable
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    // Dispatch from the rename stage
    input wire logic DISP_VALID,
    input wire fp_kind_t DISP_KIND,
    input wire tag_t DISP_TAG,
    input wire preg_t DISP_SRC_A,
    input wire preg_t DISP_SRC_B,
    input wire preg_t DISP_DST,
    input wire iq_idx_t DISP_IQ_IDX,
    output logic DISP_READY,
    // Floating-point load results
    input wire logic [1:0] LD_WE,
    input preg_t LD_DST [2],
    input word_t LD_DATA [2],
    // Branch resolution
    output logic BR_VALID,
    output tag_t BR_TAG,
    output logic BR_TAKEN,
    // Toward the integer issue queue
    fp_int_link_if.fp_end LINK
);

    localparam int NWP = 4;

    logic [DEPTH-1:0] valid;
    logic [DEPTH-1:0] issued;
    fp_kind_t kind [DEPTH];
    tag_t tag [DEPTH];
    preg_t src_a [DEPTH];
    preg_t src_b [DEPTH];
    preg_t dst [DEPTH];
    iq_idx_t iq_idx [DEPTH];

    word_t rf [NPREG];
    logic [NPREG-1:0] ready;

    function automatic logic is_zero(preg_t p);
        return p == `PREG_ZERO;
    endfunction

    function automatic logic preg_ok(preg_t p, logic [NPREG-1:0] r);
        return is_zero(p) || r[p];
    endfunction

    function automatic word_t rd_port(preg_t p, word_t v);
        return is_zero(p) ? '0 : v;
    endfunction

    function automatic fpq_idx_t sel_idx(logic [DEPTH-1:0] g);
        fpq_idx_t k;
        k = '0;
        for (int i = 0; i < DEPTH; i++) begin
            if (g[i]) begin
                k = fpq_idx_t'(i);
            end
        end
        return k;
    endfunction

    // Requests
    logic [DEPTH-1:0] req_add, req_mul, req_st0, req_st1;
    logic div_busy;
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_req
            wire live = valid[gi] & ~issued[gi];
            wire a_ok = preg_ok(src_a[gi], ready);
            wire ops_ok = a_ok & preg_ok(src_b[gi], ready);
            wire to_add = kind[gi] == OP_ADD || kind[gi] == OP_BRANCH;
            wire to_div = kind[gi] == OP_DIVSQRT && !div_busy;
            wire to_st = kind[gi] == OP_STORE || kind[gi] == OP_FTOI;
            assign req_add[gi] = live & ops_ok & (to_add | to_div);
            assign req_mul[gi] = live & ops_ok & (kind[gi] == OP_MUL);
            assign req_st0[gi] = live & a_ok & to_st & (gi % 2 == 0);
            assign req_st1[gi] = live & a_ok & to_st & (gi % 2 == 1);
        end
    endgenerate

    // Four age arbiters; the store pair splits entries by parity
    logic [DEPTH-1:0] gnt_add, gnt_mul, gnt_st0, gnt_st1;
    age_arbiter #(.N(DEPTH)) u_arb_add (.req(req_add), .tag(tag), .grant(gnt_add));
    age_arbiter #(.N(DEPTH)) u_arb_mul (.req(req_mul), .tag(tag), .grant(gnt_mul));
    age_arbiter #(.N(DEPTH)) u_arb_st0 (.req(req_st0), .tag(tag), .grant(gnt_st0));
    age_arbiter #(.N(DEPTH)) u_arb_st1 (.req(req_st1), .tag(tag), .grant(gnt_st1));

    wire [DEPTH-1:0] gnt_any = gnt_add | gnt_mul | gnt_st0 | gnt_st1;
    wire fpq_idx_t e_add = sel_idx(gnt_add);
    wire fpq_idx_t e_mul = sel_idx(gnt_mul);
    wire fpq_idx_t e_st0 = sel_idx(gnt_st0);
    wire fpq_idx_t e_st1 = sel_idx(gnt_st1);

    // Six read ports
    wire word_t add_a = rd_port(src_a[e_add], rf[src_a[e_add]]);
    wire word_t add_b = rd_port(src_b[e_add], rf[src_b[e_add]]);
    wire word_t mul_a = rd_port(src_a[e_mul], rf[src_a[e_mul]]);
    wire word_t mul_b = rd_port(src_b[e_mul], rf[src_b[e_mul]]);
    wire word_t st_d0 = rd_port(src_a[e_st0], rf[src_a[e_st0]]);
    wire word_t st_d1 = rd_port(src_a[e_st1], rf[src_a[e_st1]]);

    wire add_go = |gnt_add && kind[e_add] != OP_DIVSQRT;
    wire div_go = |gnt_add && kind[e_add] == OP_DIVSQRT;
    wire add_isbr = kind[e_add] == OP_BRANCH;

    // Add and multiply pipes; the integer add and product stand in
    // for the arithmetic cores that plug into these stages
    logic [ADD_LAT-1:0] add_v, add_br;
    preg_t add_dst [ADD_LAT];
    tag_t add_tag [ADD_LAT];
    word_t add_res [ADD_LAT];
    logic [MUL_LAT-1:0] mul_v;
    preg_t mul_dst [MUL_LAT];
    word_t mul_res [MUL_LAT];

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            add_v <= '0;
            mul_v <= '0;
        end else if (CE) begin
            add_v <= {add_v[ADD_LAT-2:0], add_go};
            mul_v <= {mul_v[MUL_LAT-2:0], |gnt_mul};
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (CE) begin
            add_br[0] <= add_isbr;
            add_dst[0] <= add_isbr ? `PREG_ZERO : dst[e_add];
            add_tag[0] <= tag[e_add];
            add_res[0] <= add_isbr ? add_a : add_a + add_b;
            mul_dst[0] <= dst[e_mul];
            mul_res[0] <= mul_a * mul_b;
            for (int s = 1; s < ADD_LAT; s++) begin
                add_br[s] <= add_br[s-1];
                add_dst[s] <= add_dst[s-1];
                add_tag[s] <= add_tag[s-1];
                add_res[s] <= add_res[s-1];
            end
            for (int s = 1; s < MUL_LAT; s++) begin
                mul_dst[s] <= mul_dst[s-1];
                mul_res[s] <= mul_res[s-1];
            end
        end
    end

    wire add_wr = add_v[ADD_LAT-1] & ~add_br[ADD_LAT-1];

    // Divide/square root: busy from grant until its result is written,
    // which keeps further ones out of the add arbiter
    logic [7:0] div_cnt;
    preg_t div_dst;
    word_t div_res;
    wire div_wr = div_busy && div_cnt == 8'h00 && !add_wr;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            div_busy <= 1'b0;
            div_cnt <= 8'h00;
        end else if (CE) begin
            if (div_go) begin
                div_busy <= 1'b1;
                div_cnt <= 8'(DIV_CYC - 1);
            end else if (div_wr) begin
                div_busy <= 1'b0;
            end else if (div_cnt != 8'h00) begin
                div_cnt <= div_cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (CE && div_go) begin
            div_dst <= dst[e_add];
            div_res <= add_a;
        end
    end

    // Four write ports: add or divide, multiply, two loads
    logic [NWP-1:0] wp_we;
    preg_t wp_dst [NWP];
    word_t wp_data [NWP];
    assign wp_we = {LD_WE, mul_v[MUL_LAT-1], add_wr | div_wr};
    assign wp_dst[0] = add_wr ? add_dst[ADD_LAT-1] : div_dst;
    assign wp_data[0] = add_wr ? add_res[ADD_LAT-1] : div_res;
    assign wp_dst[1] = mul_dst[MUL_LAT-1];
    assign wp_data[1] = mul_res[MUL_LAT-1];
    assign wp_dst[2] = LD_DST[0];
    assign wp_data[2] = LD_DATA[0];
    assign wp_dst[3] = LD_DST[1];
    assign wp_data[3] = LD_DATA[1];

    // Zero register is never stored; writes to it are dropped
    always_ff @(posedge CLK_SYS) begin
        if (CE) begin
            for (int w = 0; w < NWP; w++) begin
                if (wp_we[w] && !is_zero(wp_dst[w])) begin
                    rf[wp_dst[w]] <= wp_data[w];
                end
            end
        end
    end

    // Insertion into the lowest free entry
    wire [DEPTH-1:0] free = ~valid;
    wire [DEPTH-1:0] free_low = free & (~free + 1'b1);
    wire ins = DISP_VALID & DISP_READY;
    wire [DEPTH-1:0] ins_vec = free_low & {DEPTH{ins}};
    wire ins_dst = ins && !is_zero(DISP_DST) && DISP_KIND != OP_STORE
        && DISP_KIND != OP_FTOI && DISP_KIND != OP_BRANCH;

    // Later writes win, so a result landing the cycle a register
    // is reallocated cannot occur: rename hands out free registers only
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ready <= '1;
        end else if (CE) begin
            if (ins_dst) begin
                ready[DISP_DST] <= 1'b0;
            end
            for (int w = 0; w < NWP; w++) begin
                if (wp_we[w] && !is_zero(wp_dst[w])) begin
                    ready[wp_dst[w]] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            valid <= '0;
            issued <= '0;
        end else if (CE) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (valid[i] && issued[i]) begin
                    valid[i] <= 1'b0;
                end else if (gnt_any[i]) begin
                    issued[i] <= 1'b1;
                end else if (ins_vec[i]) begin
                    valid[i] <= 1'b1;
                    issued[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (CE) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (ins_vec[i]) begin
                    kind[i] <= DISP_KIND;
                    tag[i] <= DISP_TAG;
                    src_a[i] <= DISP_SRC_A;
                    src_b[i] <= DISP_SRC_B;
                    dst[i] <= DISP_DST;
                    iq_idx[i] <= DISP_IQ_IDX;
                end
            end
        end
    end

    // Ready is judged a cycle late, so a margin of two free entries
    // guarantees room for the single insert that may be in flight
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            DISP_READY <= 1'b0;
            BR_VALID <= 1'b0;
            BR_TAG <= '0;
            BR_TAKEN <= 1'b0;
            LINK.go <= '0;
            LINK.go_idx[0] <= '0;
            LINK.go_idx[1] <= '0;
            LINK.go_data[0] <= '0;
            LINK.go_data[1] <= '0;
        end else if (CE) begin
            DISP_READY <= $countones(free) >= `DISP_READY_MIN;
            BR_VALID <= add_v[ADD_LAT-1] & add_br[ADD_LAT-1];
            BR_TAG <= add_tag[ADD_LAT-1];
            BR_TAKEN <= add_res[ADD_LAT-1] == '0;
            LINK.go <= {|gnt_st1, |gnt_st0};
            LINK.go_idx[0] <= iq_idx[e_st0];
            LINK.go_idx[1] <= iq_idx[e_st1];
            LINK.go_data[0] <= st_d0;
            LINK.go_data[1] <= st_d1;
        end
    end

endmodule

// file: rtl/fpq_consts.svh
`ifndef FPQ_CONSTS_SVH
`define FPQ_CONSTS_SVH

`define FPQ_DEPTH 15
`define IQ_DEPTH 20
`define ARCH_REGS 31
`define SPEC_REGS 41
`define PREG_NUM 72
`define PREG_W 7
`define PREG_ZERO 7'h7F
`define INT_PREG_W 7
`define TAG_W 8
`define IQ_IDX_W 5
`define FPQ_IDX_W 4
`define DATA_W 64
`define ADD_LAT 4
`define MUL_LAT 4
`define DIVSQRT_CYCLES 12
`define STORE_PORTS 2
`define DISP_READY_MIN 2

`endif

// file: rtl/fpq_pkg.sv
package fpq_pkg;

`include "fpq_consts.svh"

typedef logic [`TAG_W-1:0] tag_t;
typedef logic [`PREG_W-1:0] preg_t;
typedef logic [`INT_PREG_W-1:0] int_preg_t;
typedef logic [`IQ_IDX_W-1:0] iq_idx_t;
typedef logic [`FPQ_IDX_W-1:0] fpq_idx_t;
typedef logic [`DATA_W-1:0] word_t;

typedef enum logic [2:0] {
    OP_ADD = 3'h0,
    OP_MUL = 3'h1,
    OP_DIVSQRT = 3'h2,
    OP_BRANCH = 3'h3,
    OP_STORE = 3'h4,
    OP_FTOI = 3'h5
} fp_kind_t;

typedef enum logic [2:0] {
    XS_IDLE = 3'h1,
    XS_WAIT = 3'h2,
    XS_REQ = 3'h4
} xfer_state_t;

endpackage

// file: rtl/int_queue_xfer_end.sv
`timescale 1ns/1ps
`include "fpq_consts.svh"
module int_queue_xfer_end
    import fpq_pkg::*;
#(
    parameter int DEPTH = `IQ_DEPTH
) (
    // Clock, reset, enable
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    // Twin entry placed by rename, same cycle as the float side
    input wire logic SLOT_VALID,
    input wire iq_idx_t SLOT_IDX,
    input wire logic SLOT_FTOI,
    input wire int_preg_t SLOT_DST,
    // Issue from the integer arbiters
    input wire logic ISSUE_VALID,
    input wire iq_idx_t ISSUE_IDX,
    // Requests toward the integer arbiters
    output logic [DEPTH-1:0] REQ,
    // Transfer result on a load write port of the integer file
    output logic LDPORT_WE,
    output int_preg_t LDPORT_DST,
    output word_t LDPORT_DATA,
    // Store data toward the store queue
    output logic ST_WE,
    output iq_idx_t ST_IDX,
    output word_t ST_DATA,
    // From the floating-point queue
    fp_int_link_if.int_end LINK
);

    xfer_state_t state [DEPTH];
    xfer_state_t next_state [DEPTH];
    logic [DEPTH-1:0] is_ftoi;
    int_preg_t dst [DEPTH];
    word_t data [DEPTH];

    wire iss_ok = ISSUE_VALID && state[ISSUE_IDX] == XS_REQ;

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            wire hit0 = LINK.go[0] && LINK.go_idx[0] == iq_idx_t'(gi);
            wire hit1 = LINK.go[1] && LINK.go_idx[1] == iq_idx_t'(gi);
            wire slot_hit = SLOT_VALID && SLOT_IDX == iq_idx_t'(gi);
            wire iss_hit = iss_ok && ISSUE_IDX == iq_idx_t'(gi);
            always_comb begin
                next_state[gi] = state[gi];
                unique case (state[gi])
                    XS_IDLE: if (slot_hit) next_state[gi] = XS_WAIT;
                    XS_WAIT: if (hit0 | hit1) next_state[gi] = XS_REQ;
                    XS_REQ: if (iss_hit) next_state[gi] = XS_IDLE;
                    default: next_state[gi] = XS_IDLE;
                endcase
            end
            always_ff @(posedge CLK_SYS) begin
                if (!RST_N) begin
                    state[gi] <= XS_IDLE;
                    REQ[gi] <= 1'b0;
                end else if (CE) begin
                    state[gi] <= next_state[gi];
                    REQ[gi] <= next_state[gi] == XS_REQ;
                end
            end
            always_ff @(posedge CLK_SYS) begin
                if (CE && slot_hit && state[gi] == XS_IDLE) begin
                    is_ftoi[gi] <= SLOT_FTOI;
                    dst[gi] <= SLOT_DST;
                end
                if (CE && state[gi] == XS_WAIT && (hit0 | hit1)) begin
                    data[gi] <= hit0 ? LINK.go_data[0] : LINK.go_data[1];
                end
            end
        end
    endgenerate

    // Completion: transfers ride the load write port, stores leave
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            LDPORT_WE <= 1'b0;
            LDPORT_DST <= '0;
            LDPORT_DATA <= '0;
            ST_WE <= 1'b0;
            ST_IDX <= '0;
            ST_DATA <= '0;
        end else if (CE) begin
            LDPORT_WE <= iss_ok & is_ftoi[ISSUE_IDX];
            LDPORT_DST <= dst[ISSUE_IDX];
            LDPORT_DATA <= data[ISSUE_IDX];
            ST_WE <= iss_ok & ~is_ftoi[ISSUE_IDX];
            ST_IDX <= ISSUE_IDX;
            ST_DATA <= data[ISSUE_IDX];
        end
    end

endmodule

// file: sim/fp_issue_queue_arbiter_tb.sv
`timescale 1ns/1ps
`include "fpq_consts.svh"
module fp_issue_queue_arbiter_tb import fpq_pkg::*;;
    logic clk_sys, rst_n, ce, disp_valid, slot_valid, slot_ftoi, issue_valid;
    fp_kind_t disp_kind;
    tag_t disp_tag, br_tag;
    preg_t src_a, src_b, dst;
    iq_idx_t iq_idx, issue_idx, st_idx;
    logic [1:0] ld_we;
    preg_t ld_dst [2];
    word_t ld_data [2];
    logic disp_ready, br_valid, br_taken, ldport_we, st_we;
    logic [`IQ_DEPTH-1:0] req;
    int_preg_t ldport_dst;
    word_t ldport_data, st_data;
    int fails = 0;
    int n_tests = 0;
    int k;

    fp_int_link_if link();
    fp_issue_queue #(.DIV_CYC(2)) i_fp_issue_queue (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce),
        .DISP_VALID(disp_valid), .DISP_KIND(disp_kind), .DISP_TAG(disp_tag),
        .DISP_SRC_A(src_a), .DISP_SRC_B(src_b), .DISP_DST(dst),
        .DISP_IQ_IDX(iq_idx), .DISP_READY(disp_ready),
        .LD_WE(ld_we), .LD_DST(ld_dst), .LD_DATA(ld_data),
        .BR_VALID(br_valid), .BR_TAG(br_tag), .BR_TAKEN(br_taken),
        .LINK(link.fp_end));
    int_queue_xfer_end i_int_queue_xfer_end (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce),
        .SLOT_VALID(slot_valid), .SLOT_IDX(iq_idx), .SLOT_FTOI(slot_ftoi),
        .SLOT_DST(dst), .ISSUE_VALID(issue_valid), .ISSUE_IDX(issue_idx),
        .REQ(req), .LDPORT_WE(ldport_we), .LDPORT_DST(ldport_dst),
        .LDPORT_DATA(ldport_data), .ST_WE(st_we), .ST_IDX(st_idx),
        .ST_DATA(st_data), .LINK(link.int_end));
    fp_issue_queue_chk chk (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .go(link.go),
        .go_idx(link.go_idx), .go_data(link.go_data));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic step();
        @(negedge clk_sys);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Holds valid high; caller lowers it once the burst is over
    task automatic disp(input fp_kind_t kind, input tag_t tag,
                        input preg_t a, input preg_t b, input preg_t d,
                        input iq_idx_t iq);
        check(disp_ready, 1'b1);
        disp_valid = 1'b1;
        disp_kind = kind;
        disp_tag = tag;
        src_a = a;
        src_b = b;
        dst = d;
        iq_idx = iq;
        slot_valid = kind == OP_STORE || kind == OP_FTOI;
        slot_ftoi = kind == OP_FTOI;
        step();
    endtask

    // Cycles until the event shows; 0 waits on branches, 1 on the link
    task automatic wait_on(input int sel, output int cnt);
        for (cnt = 0; (sel == 0 ? br_valid : |link.go) !== 1'b1; cnt++) begin
            if (cnt == 40) begin
                fails++;
                $display("[FAIL] %0t: event never came", $time);
                wrap_up();
            end else begin
                step();
            end
        end
    endtask

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        {disp_valid, slot_valid, slot_ftoi, issue_valid} = 4'h0;
        disp_kind = OP_ADD;
        {disp_tag, src_a, src_b, dst, iq_idx, issue_idx} = 39'h0;
        ld_we = 2'h0;
        ld_dst[0] = 7'h06;
        ld_dst[1] = 7'h08;
        ld_data[0] = 64'h5;
        ld_data[1] = 64'hA;
        repeat (16) step();
        check(disp_ready, 1'b0);
        check(req, 20'h0);
        rst_n = 1'b1;
        step();
        ld_we = 2'h3;
        step();
        ld_we = 2'h0;
        disp(OP_BRANCH, 8'h01, 7'h06, 7'h7F, 7'h00, 5'h00);
        disp_valid = 1'b0;
        wait_on(0, k);
        check(k, 5);
        check(br_taken, 1'b0);
        check(br_tag, 8'h01);
        step();
        check(br_valid, 1'b0);
        $display("test load_branch done");

        disp(OP_ADD, 8'h10, 7'h7F, 7'h7F, 7'h03, 5'h00);
        disp(OP_BRANCH, 8'h30, 7'h03, 7'h7F, 7'h00, 5'h00);
        disp(OP_BRANCH, 8'h20, 7'h03, 7'h7F, 7'h00, 5'h00);
        disp_valid = 1'b0;
        wait_on(0, k);
        check(k, 8);
        check(br_tag, 8'h20);
        check(br_taken, 1'b1);
        step();
        check(br_valid, 1'b1);
        check(br_tag, 8'h30);
        $display("test age_order done");

        disp(OP_MUL, 8'h40, 7'h7F, 7'h7F, 7'h04, 5'h00);
        disp(OP_BRANCH, 8'h41, 7'h04, 7'h7F, 7'h00, 5'h00);
        disp_valid = 1'b0;
        wait_on(0, k);
        check(k, 9);
        check(br_taken, 1'b1);
        $display("test multiply done");

        disp(OP_ADD, 8'h50, 7'h06, 7'h08, 7'h07, 5'h00);
        disp(OP_STORE, 8'h51, 7'h07, 7'h7F, 7'h00, 5'h03);
        disp(OP_FTOI, 8'h52, 7'h07, 7'h7F, 7'h09, 5'h04);
        disp_valid = 1'b0;
        slot_valid = 1'b0;
        check(req, 20'h0);
        check(link.go, 2'h0);
        wait_on(1, k);
        check(k, 4);
        check(link.go, 2'h3);
        check(link.go_idx[0], 5'h04);
        check(link.go_idx[1], 5'h03);
        check(link.go_data[0], 64'hF);
        check(link.go_data[1], 64'hF);
        step();
        check(link.go, 2'h0);
        check(req, 20'h18);
        issue_valid = 1'b1;
        issue_idx = 5'h03;
        step();
        check(st_we, 1'b1);
        check(st_idx, 5'h03);
        check(st_data, 64'hF);
        issue_idx = 5'h04;
        step();
        check(ldport_we, 1'b1);
        check(ldport_dst, 7'h09);
        check(ldport_data, 64'hF);
        check(st_we, 1'b0);
        issue_valid = 1'b0;
        step();
        check(req, 20'h0);
        check(ldport_we, 1'b0);
        $display("test store_handover done");

        // Second divide must wait for the first; the two frozen edges fall after the first divide's count reaches zero, while its write is still pending
        disp(OP_DIVSQRT, 8'h60, 7'h06, 7'h7F, 7'h0A, 5'h00);
        disp(OP_DIVSQRT, 8'h61, 7'h06, 7'h7F, 7'h0B, 5'h00);
        disp(OP_BRANCH, 8'h62, 7'h0B, 7'h7F, 7'h00, 5'h00);
        disp_valid = 1'b0;
        ce = 1'b0;
        repeat (2) step();
        ce = 1'b1;
        wait_on(0, k);
        check(k, 9);
        check(br_tag, 8'h62);
        check(br_taken, 1'b0);
        $display("test divide_freeze done");

        rst_n = 1'b0;
        repeat (2) step();
        check(disp_ready, 1'b0);
        check(link.go, 2'h0);
        rst_n = 1'b1;
        step();
        check(disp_ready, 1'b1);
        $display("test second_reset done");
        wrap_up();
    end
endmodule

// file: sim/fp_issue_queue_chk.sv
`timescale 1ns/1ps
`include "fpq_consts.svh"
module fp_issue_queue_chk
    import fpq_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // Hand-over link toward the integer end
    input wire logic [`STORE_PORTS-1:0] go,
    input wire iq_idx_t go_idx [`STORE_PORTS],
    input wire word_t go_data [`STORE_PORTS]
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    // No entry can be dispatched, granted and handed over this early
    a_reset_quiet: assert property ($rose(RST_N) |-> go == 2'h0 [*3])
        else $error("link pulse too soon after reset");
    a_reset_fields: assert property ($rose(RST_N) |->
        go_idx[0] == 5'h0 && go_idx[1] == 5'h0 &&
        go_data[0] == 64'h0 && go_data[1] == 64'h0)
        else $error("link fields not cleared by reset");
    a_ports_distinct: assert property (&go |-> go_idx[0] != go_idx[1])
        else $error("both store ports hand over the same twin");
    a_no_regrant0: assert property (go[0] && $past(go[0]) |->
        go_idx[0] != $past(go_idx[0]))
        else $error("port 0 handed over one twin twice");
    a_no_regrant1: assert property (go[1] && $past(go[1]) |->
        go_idx[1] != $past(go_idx[1]))
        else $error("port 1 handed over one twin twice");
    // An entry's parity fixes its port, so a twin never hops ports
    a_swap_01: assert property (go[1] && $past(go[0]) |->
        go_idx[1] != $past(go_idx[0]))
        else $error("twin moved from port 0 to port 1");
    a_swap_10: assert property (go[0] && $past(go[1]) |->
        go_idx[0] != $past(go_idx[1]))
        else $error("twin moved from port 1 to port 0");
    a_twin_range: assert property (|go |->
        (!go[0] || go_idx[0] < `IQ_DEPTH) && (!go[1] || go_idx[1] < `IQ_DEPTH))
        else $error("twin index outside integer queue");
    c_dual_store: cover property (&go);
endmodule
